// ===== hdl/wac_combiner.sv
// Purpose: merges sample hits per time bucket (last-hit, average, envelope)
// Assumes: samples synchronous to REF_CLK, bucket index from sweep logic
// Notes: probe scale factors only rescale reported span and offset
`timescale 1ns/100ps
`default_nettype none
module wac_combiner (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // register port
  input wire wac_pkg::wac_bus_req_type BUS_REQ,
  output logic [31:0] RD_DATA,
  // sample stream
  input wire wac_pkg::wac_sample_type SAMPLE,
  // status
  output logic [wac_pkg::NUM_BUCKETS-1:0] BUCKET_DONE,
  output logic [2:0] ACTIVE_MODE
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n;
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic cmd_reset;
  logic launch;
  assign wr = BUS_REQ.wr;
  assign rd = BUS_REQ.rd;
  assign addr = BUS_REQ.addr;
  assign wdata = BUS_REQ.wdata;
  assign cmd_reset = wr && addr == wac_pkg::ADDR_CMD_RESET;
  assign launch = wr && addr == wac_pkg::ADDR_LAUNCH;

  // nearest power of two, ties round up
  function automatic logic [3:0] wac_pow2_log(input logic [11:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 12; i++)
      if (v[i])
        p = 4'(i);
    if (p != 4'h0 && p != wac_pkg::LOG_MAX && v[p-4'h1])
      p = p + 4'h1;
    return p;
  endfunction

  // -------------------------------------------------------------
  // combining control
  // -------------------------------------------------------------
  logic avg_en_q;
  logic type_env_q;
  logic [wac_pkg::COUNT_W-1:0] count_raw_q;
  logic [wac_pkg::COUNT_W-1:0] count_clamped;
  logic [wac_pkg::LOG_W-1:0] avg_log;
  wac_pkg::wac_mode_type mode;
  // clamping keeps count_raw_q always in range
  assign count_clamped = (wdata == 32'h0000_0000) ? wac_pkg::COUNT_MIN :
    (wdata > 32'(wac_pkg::COUNT_MAX)) ? wac_pkg::COUNT_MAX : wdata[11:0];
  assign avg_log = wac_pow2_log(count_raw_q);
  always_comb
  begin
    if (avg_en_q)
      mode = wac_pkg::MODE_AVG;
    else if (type_env_q)
      mode = wac_pkg::MODE_ENV;
    else
      mode = wac_pkg::MODE_LAST;
  end

  always_ff @(posedge REF_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      avg_en_q <= 1'b0;
      type_env_q <= 1'b0;
    end
    else if (cmd_reset)
    begin
      avg_en_q <= 1'b0;
      type_env_q <= 1'b0;
    end
    else if (wr && addr == wac_pkg::ADDR_AVG_ENABLE)
    begin
      avg_en_q <= wdata[0];
      if (!wdata[0])
        type_env_q <= 1'b0;
    end
    else if (wr && addr == wac_pkg::ADDR_COMBINE_TYPE)
      type_env_q <= wdata[0];
  end

  // raw value kept in every mode so envelope readback can return it
  always_ff @(posedge REF_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      count_raw_q <= wac_pkg::COUNT_RST;
    else if (cmd_reset)
      count_raw_q <= wac_pkg::COUNT_RST;
    else if (wr && addr == wac_pkg::ADDR_AVG_COUNT)
      count_raw_q <= count_clamped;
  end

  // -------------------------------------------------------------
  // probe scale factors
  // -------------------------------------------------------------
  logic [wac_pkg::FACTOR_W-1:0] factor_q [wac_pkg::NUM_INPUTS];
  logic [wac_pkg::SPAN_W-1:0] span_q [wac_pkg::NUM_INPUTS];
  logic [wac_pkg::SPAN_W-1:0] offs_q [wac_pkg::NUM_INPUTS];
  logic [31:0] span_scaled_q [wac_pkg::NUM_INPUTS];
  logic [31:0] offs_scaled_q [wac_pkg::NUM_INPUTS];
  logic [wac_pkg::FACTOR_W-1:0] factor_clamped;
  assign factor_clamped = (wdata < 32'(wac_pkg::FACTOR_MIN)) ? wac_pkg::FACTOR_MIN :
    (wdata > 32'(wac_pkg::FACTOR_MAX)) ? wac_pkg::FACTOR_MAX : wdata[13:0];

  for (genvar i = 0; i < wac_pkg::NUM_INPUTS; i++)
  begin : g_input
    logic sel_f;
    logic sel_s;
    logic sel_o;
    assign sel_f = wr && addr == wac_pkg::ADDR_SCALE_BASE + 8'(4 * i);
    assign sel_s = wr && addr == wac_pkg::ADDR_SPAN_BASE + 8'(4 * i);
    assign sel_o = wr && addr == wac_pkg::ADDR_OFFSET_BASE + 8'(4 * i);
    always_ff @(posedge REF_CLK or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
        factor_q[i] <= wac_pkg::FACTOR_UNITY;
      else if (cmd_reset)
        factor_q[i] <= wac_pkg::FACTOR_UNITY;
      else if (sel_f)
        factor_q[i] <= factor_clamped;
    end
    // span and offset are held as written, unscaled; host sees them scaled
    always_ff @(posedge REF_CLK or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        span_q[i] <= wac_pkg::SPAN_RST;
        offs_q[i] <= wac_pkg::SPAN_RST;
      end
      else
      begin
        if (sel_s)
          span_q[i] <= wdata[15:0];
        if (sel_o)
          offs_q[i] <= wdata[15:0];
      end
    end
    // reported values follow the factor one cycle after it changes
    always_ff @(posedge REF_CLK or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        span_scaled_q[i] <= 32'h0000_0000;
        offs_scaled_q[i] <= 32'h0000_0000;
      end
      else
      begin
        span_scaled_q[i] <= 32'(span_q[i] * factor_q[i]);
        offs_scaled_q[i] <= 32'(offs_q[i] * factor_q[i]);
      end
    end
    property p_factor_range;
      @(posedge REF_CLK) disable iff (!rst_sync_n)
      factor_q[i] >= wac_pkg::FACTOR_MIN && factor_q[i] <= wac_pkg::FACTOR_MAX;
    endproperty
    a_factor_range: assert property (p_factor_range)
      else $error("scale factor out of range");
  end

  // -------------------------------------------------------------
  // bucket storage
  // -------------------------------------------------------------
  logic [wac_pkg::ACC_W-1:0] acc_q [wac_pkg::NUM_BUCKETS];
  logic [wac_pkg::COUNT_W-1:0] hits_q [wac_pkg::NUM_BUCKETS];
  logic [wac_pkg::SAMPLE_W-1:0] last_q [wac_pkg::NUM_BUCKETS];
  logic [wac_pkg::SAMPLE_W-1:0] min_q [wac_pkg::NUM_BUCKETS];
  logic [wac_pkg::SAMPLE_W-1:0] max_q [wac_pkg::NUM_BUCKETS];
  logic [wac_pkg::NUM_BUCKETS-1:0] done_q;
  logic [wac_pkg::COUNT_W-1:0] need;
  assign need = (mode == wac_pkg::MODE_AVG) ?
    wac_pkg::COUNT_W'(12'h001 << avg_log) : wac_pkg::COUNT_MIN;

  // samples are combined unscaled; the factor never reaches this path
  for (genvar b = 0; b < wac_pkg::NUM_BUCKETS; b++)
  begin : g_bucket
    logic hit;
    logic take;
    assign hit = SAMPLE.valid && SAMPLE.bucket == 3'(b);
    // averaging stops at the count so the shift gives an exact mean;
    // the live hit count is used because done_q lags back-to-back samples
    assign take = hit && !(mode == wac_pkg::MODE_AVG && hits_q[b] >= need);
    always_ff @(posedge REF_CLK or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        acc_q[b] <= 19'h0;
        hits_q[b] <= 12'h000;
        last_q[b] <= 8'h00;
        min_q[b] <= 8'h00;
        max_q[b] <= 8'h00;
      end
      else if (launch)
      begin
        acc_q[b] <= 19'h0;
        hits_q[b] <= 12'h000;
        min_q[b] <= 8'h00;
        max_q[b] <= 8'h00;
      end
      else if (take)
      begin
        acc_q[b] <= acc_q[b] + 19'(SAMPLE.data);
        hits_q[b] <= (hits_q[b] == wac_pkg::COUNT_MAX) ? hits_q[b] : hits_q[b] + 12'h001;
        last_q[b] <= SAMPLE.data;
        if (hits_q[b] == 12'h000 || SAMPLE.data < min_q[b])
          min_q[b] <= SAMPLE.data;
        if (hits_q[b] == 12'h000 || SAMPLE.data > max_q[b])
          max_q[b] <= SAMPLE.data;
      end
    end
    always_ff @(posedge REF_CLK or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
        done_q[b] <= 1'b0;
      else if (launch)
        done_q[b] <= 1'b0;
      else
        done_q[b] <= hits_q[b] >= need;
    end
  end

  // -------------------------------------------------------------
  // readback
  // -------------------------------------------------------------
  logic [wac_pkg::BUCKET_W-1:0] sel_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_mux;
  logic [2:0] mode_q;
  logic [wac_pkg::COUNT_W-1:0] count_rb;
  logic [wac_pkg::ACC_W-1:0] mean;
  assign mean = acc_q[sel_q] >> avg_log;
  always_comb
  begin
    unique case (mode)
      wac_pkg::MODE_AVG: count_rb = wac_pkg::COUNT_W'(12'h001 << avg_log);
      wac_pkg::MODE_ENV: count_rb = count_raw_q;
      wac_pkg::MODE_LAST: count_rb = wac_pkg::COUNT_MIN;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      sel_q <= 3'h0;
    else if (wr && addr == wac_pkg::ADDR_BUCKET_SEL)
      sel_q <= wdata[2:0];
  end
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int i = 0; i < wac_pkg::NUM_INPUTS; i++)
    begin
      if (addr == wac_pkg::ADDR_SCALE_BASE + 8'(4 * i))
        rd_mux = 32'(factor_q[i]);
      if (addr == wac_pkg::ADDR_SPAN_BASE + 8'(4 * i))
        rd_mux = span_scaled_q[i];
      if (addr == wac_pkg::ADDR_OFFSET_BASE + 8'(4 * i))
        rd_mux = offs_scaled_q[i];
    end
    if (addr == wac_pkg::ADDR_AVG_ENABLE)
      rd_mux = {31'h0, avg_en_q};
    if (addr == wac_pkg::ADDR_COMBINE_TYPE)
      rd_mux = {31'h0, type_env_q};
    if (addr == wac_pkg::ADDR_AVG_COUNT)
      rd_mux = {20'h00000, count_rb};
    if (addr == wac_pkg::ADDR_BUCKET_SEL)
      rd_mux = {29'h0, sel_q};
    if (addr == wac_pkg::ADDR_DONE)
      rd_mux = {24'h00_0000, done_q};
    if (addr == wac_pkg::ADDR_RESULT)
    begin
      unique case (mode)
        wac_pkg::MODE_AVG: rd_mux = {4'h0, hits_q[sel_q], 8'h00, mean[7:0]};
        wac_pkg::MODE_ENV: rd_mux = {4'h0, hits_q[sel_q], max_q[sel_q], min_q[sel_q]};
        wac_pkg::MODE_LAST: rd_mux = {4'h0, hits_q[sel_q], 8'h00, last_q[sel_q]};
      endcase
    end
  end
  always_ff @(posedge REF_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_data_q <= 32'h0000_0000;
    else if (rd)
      rd_data_q <= rd_mux;
    else
      rd_data_q <= 32'h0000_0000;
  end
  always_ff @(posedge REF_CLK or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      mode_q <= wac_pkg::MODE_LAST;
    else
      mode_q <= mode;
  end
  assign RD_DATA = rd_data_q;
  assign BUCKET_DONE = done_q;
  assign ACTIVE_MODE = mode_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_type_forced;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (wr && addr == wac_pkg::ADDR_AVG_ENABLE && !wdata[0]) |=> !type_env_q && !avg_en_q;
  endproperty
  a_type_forced: assert property (p_type_forced)
    else $error("type not forced to last-hit");
  property p_cmd_reset;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    cmd_reset |=> count_raw_q == wac_pkg::COUNT_RST && !avg_en_q && !type_env_q;
  endproperty
  a_cmd_reset: assert property (p_cmd_reset)
    else $error("reset command defaults wrong");
  property p_last_count;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (rd && addr == wac_pkg::ADDR_AVG_COUNT && mode == wac_pkg::MODE_LAST)
      |=> rd_data_q == 32'h0000_0001;
  endproperty
  a_last_count: assert property (p_last_count)
    else $error("last-hit count readback not one");
  property p_env_count;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (rd && addr == wac_pkg::ADDR_AVG_COUNT && mode == wac_pkg::MODE_ENV)
      |=> rd_data_q == 32'($past(count_raw_q));
  endproperty
  a_env_count: assert property (p_env_count)
    else $error("envelope count readback wrong");
  property p_avg_pow2;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (rd && addr == wac_pkg::ADDR_AVG_COUNT && mode == wac_pkg::MODE_AVG)
      |=> $onehot(rd_data_q) && rd_data_q <= 32'h0000_0800;
  endproperty
  a_avg_pow2: assert property (p_avg_pow2)
    else $error("averaging count not a power of two");
  property p_launch_clear;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    launch |=> hits_q[0] == 12'h000 && acc_q[0] == 19'h0 && min_q[0] == 8'h00
      && max_q[0] == 8'h00 && done_q == 8'h00;
  endproperty
  a_launch_clear: assert property (p_launch_clear)
    else $error("launch did not clear bucket");
  property p_avg_done;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (mode == wac_pkg::MODE_AVG && $stable(avg_log) && $rose(done_q[0]))
      |-> hits_q[0] >= $past(need);
  endproperty
  a_avg_done: assert property (p_avg_done)
    else $error("bucket complete too early");
  property p_last_hit;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    (!launch && SAMPLE.valid && SAMPLE.bucket == 3'h0 && mode == wac_pkg::MODE_LAST)
      |=> last_q[0] == $past(SAMPLE.data);
  endproperty
  a_last_hit: assert property (p_last_hit)
    else $error("last-hit sample not kept");
  property p_env_order;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    hits_q[0] != 12'h000 |-> min_q[0] <= max_q[0];
  endproperty
  a_env_order: assert property (p_env_order)
    else $error("envelope min above max");
  property p_rd_once;
    @(posedge REF_CLK) disable iff (!rst_sync_n)
    !rd |=> rd_data_q == 32'h0000_0000;
  endproperty
  a_rd_once: assert property (p_rd_once)
    else $error("read data outside its cycle");
endmodule // wac_combiner
`default_nettype wire

// ===== hdl/wac_pkg.sv
// Purpose: shared constants and types for the acquisition combiner
// Assumes: 32-bit plain register port, byte offsets
// Notes: probe scale factor is held in tenths
package wac_pkg;
  localparam int unsigned NUM_INPUTS = 4;
  localparam int unsigned NUM_BUCKETS = 8;
  localparam int unsigned BUCKET_W = 3;
  localparam int unsigned SAMPLE_W = 8;
  localparam int unsigned COUNT_W = 12;
  localparam int unsigned LOG_W = 4;
  localparam int unsigned ACC_W = 19;
  localparam int unsigned FACTOR_W = 14;
  localparam int unsigned SPAN_W = 16;
  // -------------------------------------------------------------
  // register offsets
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_AVG_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_COMBINE_TYPE = 8'h04;
  localparam logic [7:0] ADDR_AVG_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CMD_RESET = 8'h0C;
  localparam logic [7:0] ADDR_LAUNCH = 8'h10;
  localparam logic [7:0] ADDR_BUCKET_SEL = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_DONE = 8'h1C;
  localparam logic [7:0] ADDR_SCALE_BASE = 8'h20;
  localparam logic [7:0] ADDR_SPAN_BASE = 8'h30;
  localparam logic [7:0] ADDR_OFFSET_BASE = 8'h40;
  // -------------------------------------------------------------
  // values and limits
  // -------------------------------------------------------------
  localparam logic [COUNT_W-1:0] COUNT_RST = 12'h008;
  localparam logic [COUNT_W-1:0] COUNT_MIN = 12'h001;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 12'h800;
  localparam logic [LOG_W-1:0] LOG_MAX = 4'hB;
  localparam logic [FACTOR_W-1:0] FACTOR_MIN = 14'h0009;
  localparam logic [FACTOR_W-1:0] FACTOR_MAX = 14'h2710;
  localparam logic [FACTOR_W-1:0] FACTOR_UNITY = 14'h000A;
  localparam logic [SPAN_W-1:0] SPAN_RST = 16'h0000;
  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_LAST = 3'b001,
    MODE_AVG = 3'b010,
    MODE_ENV = 3'b100
  } wac_mode_type;
  typedef struct packed {
    logic valid;
    logic [BUCKET_W-1:0] bucket;
    logic [SAMPLE_W-1:0] data;
  } wac_sample_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } wac_bus_req_type;
endpackage

// ===== dv/wac_host_model.sv
// Purpose: host-side master model for the combiner register port
// Assumes: one clock, strobes one cycle long, read data in the cycle after rd
// Notes: idle cycles show inverted address and data so stale values never look valid
`timescale 1ns/100ps
`default_nettype none
module wac_host_model (
  // clock
  input wire logic clk,
  // register port
  output var wac_pkg::wac_bus_req_type bus_req,
  input wire logic [31:0] rd_data
);
  initial
  begin
    bus_req = '0;
  end
  // -------------------------------------------------------------
  // bus cycles
  // -------------------------------------------------------------
  task automatic reg_write(input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    bus_req <= '{1'b1, 1'b0, addr, wdata};
    @(posedge clk);
    bus_req <= '{1'b0, 1'b0, ~addr, ~wdata};
  endtask
  task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk);
    bus_req <= '{1'b0, 1'b1, addr, 32'h0000_0000};
    @(posedge clk);
    bus_req <= '{1'b0, 1'b0, ~addr, 32'hFFFF_FFFF};
    #1;
    data = rd_data;
  endtask
  // callers finish all combining setup before this
  task automatic launch_acq();
    reg_write(wac_pkg::ADDR_LAUNCH, 32'h0000_0001);
  endtask
endmodule // wac_host_model
`default_nettype wire

// ===== dv/test_waveform_acquisition_combiner.sv
// Purpose: self-checking bench for the acquisition combiner
// Assumes: host model drives the register port, bench drives samples
// Notes: fixed waits follow the registered latencies of the port
`timescale 1ns/100ps
`default_nettype none
module test_waveform_acquisition_combiner;
  logic ref_clk;
  logic reset_n;
  wac_pkg::wac_bus_req_type bus_req;
  wac_pkg::wac_sample_type sample;
  logic [31:0] rd_data;
  logic [wac_pkg::NUM_BUCKETS-1:0] bucket_done;
  logic [2:0] active_mode;
  int num_errors;
  int n_compared;
  logic [31:0] cnt_in [4] = '{32'h0, 32'h1388, 32'h3, 32'h64};
  logic [31:0] cnt_exp [4] = '{32'h1, 32'h800, 32'h4, 32'h80};

  wac_combiner dut (.REF_CLK(ref_clk), .RESET_N(reset_n), .BUS_REQ(bus_req),
    .RD_DATA(rd_data), .SAMPLE(sample), .BUCKET_DONE(bucket_done),
    .ACTIVE_MODE(active_mode));
  wac_host_model host (.clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check_reg(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    host.reg_read(addr, got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t addr %h got %h expected %h", $time, addr, got, exp);
    end
  endtask
  // mode and done settle a few edges after the causing write or sample
  task automatic check_status(input logic [2:0] mode, input logic [7:0] done);
    repeat (3) @(posedge ref_clk);
    #1;
    n_compared++;
    if ({active_mode, bucket_done} !== {mode, done})
    begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time,
        {active_mode, bucket_done}, {mode, done});
    end
  endtask
  task automatic send(input logic [2:0] b, input logic [7:0] d);
    @(posedge ref_clk);
    sample <= '{1'b1, b, d};
    @(posedge ref_clk);
    sample <= '{1'b0, ~b, ~d};
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    host.reg_write(addr, data);
  endtask
  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    sample = '{1'b0, 3'h0, 8'h00};
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values, unmapped place
    check_reg(wac_pkg::ADDR_AVG_ENABLE, 32'h0);
    check_reg(wac_pkg::ADDR_COMBINE_TYPE, 32'h0);
    check_reg(wac_pkg::ADDR_AVG_COUNT, 32'h1);
    check_reg(8'hFC, 32'h0);
    for (int i = 0; i < 4; i++)
      check_reg(wac_pkg::ADDR_SCALE_BASE + 8'(4 * i), 32'hA);
    check_status(3'b001, 8'h00);
    // averaging: count clamp and rounding, type override
    wr(wac_pkg::ADDR_AVG_ENABLE, 32'h1);
    check_reg(wac_pkg::ADDR_AVG_ENABLE, 32'h1);
    check_reg(wac_pkg::ADDR_AVG_COUNT, 32'h8);
    for (int i = 0; i < 4; i++)
    begin
      wr(wac_pkg::ADDR_AVG_COUNT, cnt_in[i]);
      check_reg(wac_pkg::ADDR_AVG_COUNT, cnt_exp[i]);
    end
    wr(wac_pkg::ADDR_COMBINE_TYPE, 32'h1);
    check_reg(wac_pkg::ADDR_COMBINE_TYPE, 32'h1);
    check_status(3'b010, 8'h00);
    // averaging acquisition of four hits, fifth refused
    wr(wac_pkg::ADDR_AVG_COUNT, 32'h4);
    wr(wac_pkg::ADDR_BUCKET_SEL, 32'h1);
    host.launch_acq();
    send(3'h1, 8'h01);
    send(3'h1, 8'h02);
    send(3'h1, 8'h03);
    check_status(3'b010, 8'h00);
    send(3'h1, 8'h04);
    check_status(3'b010, 8'h02);
    send(3'h1, 8'h09);
    check_reg(wac_pkg::ADDR_RESULT, 32'h0004_0002);
    // switching averaging off forces the stored type back
    wr(wac_pkg::ADDR_AVG_ENABLE, 32'h0);
    check_reg(wac_pkg::ADDR_COMBINE_TYPE, 32'h0);
    check_status(3'b001, 8'h02);
    // envelope acquisition
    wr(wac_pkg::ADDR_COMBINE_TYPE, 32'h1);
    wr(wac_pkg::ADDR_AVG_COUNT, 32'h64);
    check_reg(wac_pkg::ADDR_AVG_COUNT, 32'h64);
    wr(wac_pkg::ADDR_BUCKET_SEL, 32'h2);
    host.launch_acq();
    check_reg(wac_pkg::ADDR_DONE, 32'h0);
    send(3'h2, 8'h07);
    send(3'h2, 8'h03);
    send(3'h2, 8'h0C);
    check_status(3'b100, 8'h04);
    check_reg(wac_pkg::ADDR_RESULT, 32'h0003_0C03);
    // last-hit acquisition
    wr(wac_pkg::ADDR_COMBINE_TYPE, 32'h0);
    wr(wac_pkg::ADDR_AVG_COUNT, 32'h5);
    check_reg(wac_pkg::ADDR_AVG_COUNT, 32'h1);
    host.launch_acq();
    check_reg(wac_pkg::ADDR_RESULT, 32'h0000_000C);
    wr(wac_pkg::ADDR_BUCKET_SEL, 32'h0);
    send(3'h0, 8'h05);
    send(3'h0, 8'h09);
    check_status(3'b001, 8'h01);
    check_reg(wac_pkg::ADDR_RESULT, 32'h0002_0009);
    check_reg(wac_pkg::ADDR_DONE, 32'h1);
    // probe scale factors and scaled span/offset
    wr(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'h4E20);
    check_reg(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'h2710);
    wr(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'h5);
    check_reg(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'h9);
    wr(wac_pkg::ADDR_SPAN_BASE + 8'h04, 32'h7);
    wr(wac_pkg::ADDR_OFFSET_BASE + 8'h04, 32'h3);
    wr(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'h14);
    repeat (2) @(posedge ref_clk);
    check_reg(wac_pkg::ADDR_SPAN_BASE + 8'h04, 32'h8C);
    check_reg(wac_pkg::ADDR_OFFSET_BASE + 8'h04, 32'h3C);
    check_reg(wac_pkg::ADDR_SCALE_BASE, 32'hA);
    // reset command
    wr(wac_pkg::ADDR_AVG_ENABLE, 32'h1);
    wr(wac_pkg::ADDR_COMBINE_TYPE, 32'h1);
    wr(wac_pkg::ADDR_CMD_RESET, 32'h1);
    check_reg(wac_pkg::ADDR_AVG_ENABLE, 32'h0);
    check_reg(wac_pkg::ADDR_COMBINE_TYPE, 32'h0);
    check_reg(wac_pkg::ADDR_SCALE_BASE + 8'h04, 32'hA);
    wr(wac_pkg::ADDR_AVG_ENABLE, 32'h1);
    check_reg(wac_pkg::ADDR_AVG_COUNT, 32'h8);
    wrap_up();
  end
endmodule // test_waveform_acquisition_combiner
`default_nettype wire
